// *** gpp_pkg.sv ***
// package for the eight-bit general-purpose port with pad control
// shared by the port top and its per-pin pad slice
package gpp_pkg;

    localparam int          GPP_WIDTH         = 8;
    localparam int          GPP_ADDR_W        = 12;
    localparam logic [31:0] GPP_BASE_ADDR     = 32'h4000_01C0;

    // register byte offsets of the second port (relative to base)
    localparam logic [11:0] OFS_PORTB_DATA    = 12'h000;
    localparam logic [11:0] OFS_PORTB_OE      = 12'h004;
    localparam logic [11:0] OFS_PORTB_FSEL1   = 12'h008;
    localparam logic [11:0] OFS_PORTB_OD      = 12'h028;
    localparam logic [11:0] OFS_PORTB_PU      = 12'h02C;
    localparam logic [11:0] OFS_PORTB_PD      = 12'h030;
    localparam logic [11:0] OFS_PORTB_IE      = 12'h038;

    // pad-control registers of the first port, placed above the second port's map
    localparam logic [11:0] OFS_PORTA_OD      = 12'h128;
    localparam logic [11:0] OFS_PORTA_PU      = 12'h12C;
    localparam logic [11:0] OFS_PORTA_PD      = 12'h130;
    localparam logic [11:0] OFS_PORTA_IE      = 12'h138;

    // field layout: one bit per pin in the low byte
    localparam int          FLD_PIN_LSB       = 0;
    localparam int          FLD_PIN_MSB       = 7;
    localparam int          FSEL1_MSB         = 2;

    // reset values
    localparam logic [7:0]  RST_PIN_BYTE      = 8'h00;
    localparam logic [31:0] RST_READ_WORD     = 32'h0000_0000;

    // pin function chosen by the function-select bit
    typedef enum logic [1:0] {
        GPP_FN_PORT = 2'b01,
        GPP_FN_ALT  = 2'b10
    } gpp_fn_e;

endpackage : gpp_pkg

// *** gpp_pad_slice.sv ***
// one pin of the port: drive, open-drain, pull and input gating
// assumes pin input is synchronous to core_clk
`timescale 1ns/100ps
module gpp_pad_slice
    import gpp_pkg::*;
(
    // configuration of this pin
    input  wire logic outData,
    input  wire logic outEnable,
    input  wire logic openDrain,
    input  wire logic pullUpEn,
    input  wire logic pullDownEn,
    input  wire logic inputEn,
    input  wire logic altSel,
    // pad
    input  wire logic padIn,
    output logic      padOut,
    output logic      padOe,
    output logic      padPullUp,
    output logic      padPullDown,
    // core side
    output logic      inGated,
    output logic      analogIn
);

    gpp_fn_e pinFn;

    // function of the pin
    assign pinFn = altSel ? GPP_FN_ALT : GPP_FN_PORT;

    // open drain only pulls low; cmos drives both levels
    always_comb
    begin
        padOut = outData;
        padOe  = 1'b0;
        if (pinFn == GPP_FN_PORT && outEnable)
        begin
            if (openDrain)
            begin
                padOut = 1'b0;
                padOe  = ~outData;
            end
            else
            begin
                padOe  = 1'b1;
            end
        end
    end

    // resistor controls straight from the pad registers
    assign padPullUp   = pullUpEn;
    assign padPullDown = pullDownEn;

    // input buffer blocks the level when disabled
    assign inGated  = padIn & inputEn;
    assign analogIn = padIn;

endmodule : gpp_pad_slice

// *** gpp_port.sv ***
// Contract
// - eight-pin port, one bit per pin
// - direction set per pin
// - pins feed converter and interrupt lines
// - reset: port mode, everything disabled
// - base, data, enable, function offsets
// - open-drain, pull-up, pull-down, input offsets
// - output enable bit drives pin; pins 2..0 ignore it while set to the alternate function
// - open-drain bit selects drain-only drive
// - pull-up bit switches pull-up
// - pull-down bit switches pull-down
// - input enable bit gates input
//
// top of the eight-bit port: register file and eight pad slices
// assumes a simple strobe bus on core_clk; address is offset from base
//
// Implementation choice: strobed register access.
`timescale 1ns/100ps
module gpp_port
    import gpp_pkg::*;
(
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // register bus
    input  wire logic [GPP_ADDR_W-1:0] regAddr,
    input  wire logic [31:0]           regWdata,
    input  wire logic                  regWrite,
    input  wire logic                  regRead,
    output logic      [31:0]           regRdata,
    // second port pads
    input  wire logic [7:0]            pinIn,
    output logic      [7:0]            pinOut,
    output logic      [7:0]            pinOe,
    output logic      [7:0]            pinPullUp,
    output logic      [7:0]            pinPullDown,
    // alternate functions of the second port
    output logic      [7:0]            adcIn,
    output logic      [2:0]            extIrq,
    // first port pad controls
    output logic      [7:0]            portaOpenDrain,
    output logic      [7:0]            portaPullUp,
    output logic      [7:0]            portaPullDown,
    output logic      [7:0]            portaInputEn
);

    logic [7:0] dataR;
    logic [7:0] oeR;
    logic [2:0] fselR;
    logic [7:0] odR;
    logic [7:0] puR;
    logic [7:0] pdR;
    logic [7:0] ieR;
    logic [7:0] aOdR;
    logic [7:0] aPuR;
    logic [7:0] aPdR;
    logic [7:0] aIeR;
    logic [7:0] inGated;
    logic [7:0] altSel;
    logic [7:0] pinView;
    logic [7:0] readByte;
    logic       readHit;
    logic [7:0] wByte;

    // only the low byte of a write is kept
    assign wByte = regWdata[FLD_PIN_MSB:FLD_PIN_LSB];

    // second port data and direction
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            dataR <= RST_PIN_BYTE;
            oeR   <= RST_PIN_BYTE;
            fselR <= RST_PIN_BYTE[FSEL1_MSB:0];
        end
        else if (regWrite)
        begin
            case (regAddr)
                OFS_PORTB_DATA:  dataR <= wByte;
                OFS_PORTB_OE:    oeR   <= wByte;
                OFS_PORTB_FSEL1: fselR <= wByte[FSEL1_MSB:0];
                default:         ;
            endcase
        end
    end

    // second port pad controls
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            odR <= RST_PIN_BYTE;
            puR <= RST_PIN_BYTE;
            pdR <= RST_PIN_BYTE;
            ieR <= RST_PIN_BYTE;
        end
        else if (regWrite)
        begin
            case (regAddr)
                OFS_PORTB_OD: odR <= wByte;
                OFS_PORTB_PU: puR <= wByte;
                OFS_PORTB_PD: pdR <= wByte;
                OFS_PORTB_IE: ieR <= wByte;
                default:      ;
            endcase
        end
    end

    // first port pad controls, same layout
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            aOdR <= RST_PIN_BYTE;
            aPuR <= RST_PIN_BYTE;
            aPdR <= RST_PIN_BYTE;
            aIeR <= RST_PIN_BYTE;
        end
        else if (regWrite)
        begin
            case (regAddr)
                OFS_PORTA_OD: aOdR <= wByte;
                OFS_PORTA_PU: aPuR <= wByte;
                OFS_PORTA_PD: aPdR <= wByte;
                OFS_PORTA_IE: aIeR <= wByte;
                default:      ;
            endcase
        end
    end

    assign portaOpenDrain = aOdR;
    assign portaPullUp    = aPuR;
    assign portaPullDown  = aPdR;
    assign portaInputEn   = aIeR;

    // function select covers pins 2..0 only
    assign altSel = {5'h00, fselR};

    // per-pin pad slices
    genvar gi;
    generate
        for (gi = 0; gi < GPP_WIDTH; gi++)
        begin : g_pin
            gpp_pad_slice u_pad (
                .outData     (dataR[gi]),
                .outEnable   (oeR[gi]),
                .openDrain   (odR[gi]),
                .pullUpEn    (puR[gi]),
                .pullDownEn  (pdR[gi]),
                .inputEn     (ieR[gi]),
                .altSel      (altSel[gi]),
                .padIn       (pinIn[gi]),
                .padOut      (pinOut[gi]),
                .padOe       (pinOe[gi]),
                .padPullUp   (pinPullUp[gi]),
                .padPullDown (pinPullDown[gi]),
                .inGated     (inGated[gi]),
                .analogIn    (adcIn[gi])
            );
        end
    endgenerate

    // external interrupt lines take the gated input when selected
    assign extIrq = inGated[2:0] & fselR;

    // data read: pin level where input enabled, else zero
    assign pinView = inGated;

    // read decode
    always_comb
    begin
        readHit  = 1'b1;
        readByte = 8'h00;
        case (regAddr)
            OFS_PORTB_DATA:  readByte = pinView;
            OFS_PORTB_OE:    readByte = oeR;
            OFS_PORTB_FSEL1: readByte = {5'h00, fselR};
            OFS_PORTB_OD:    readByte = odR;
            OFS_PORTB_PU:    readByte = puR;
            OFS_PORTB_PD:    readByte = pdR;
            OFS_PORTB_IE:    readByte = ieR;
            OFS_PORTA_OD:    readByte = aOdR;
            OFS_PORTA_PU:    readByte = aPuR;
            OFS_PORTA_PD:    readByte = aPdR;
            OFS_PORTA_IE:    readByte = aIeR;
            default:         readHit  = 1'b0;
        endcase
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            regRdata <= RST_READ_WORD;
        else if (regRead && readHit)
            regRdata <= {24'h000000, readByte};
        else
            regRdata <= RST_READ_WORD;
    end

endmodule : gpp_port

// *** gpp_port_checker.sv ***
// assertions on the port top: bus answers, pulls, reset, interrupt gating
// sees the port top's ports only; bound after the module
`timescale 1ns/100ps
module gpp_port_checker
    import gpp_pkg::*;
(
    // clock, reset, bus
    input wire logic                  core_clk,
    input wire logic                  rst,
    input wire logic [GPP_ADDR_W-1:0] regAddr,
    input wire logic [31:0]           regWdata,
    input wire logic                  regWrite,
    input wire logic                  regRead,
    input wire logic [31:0]           regRdata,
    // pads
    input wire logic [7:0]            pinIn,
    input wire logic [7:0]            pinOe,
    input wire logic [7:0]            pinPullUp,
    input wire logic [7:0]            pinPullDown,
    input wire logic [2:0]            extIrq,
    input wire logic [7:0]            portaOpenDrain
);
    // one clock domain
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // bus answers and pad relations
    rdata_idle_a: assert property (!$past(regRead) |-> regRdata == 32'h0)
        else $error("read data not zero when idle");
    upper_zero_a: assert property (regRdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    reset_quiet_a: assert property ($past(rst) |-> (pinOe | pinPullUp) == 8'h0
        && pinPullDown == 8'h0 && extIrq == 3'h0) else $error("pads active after reset");
    pullup_write_a: assert property ($past(regWrite) && $past(regAddr) == OFS_PORTB_PU
        |-> pinPullUp == 8'($past(regWdata))) else $error("pull-up not written");
    pulldn_write_a: assert property ($past(regWrite) && $past(regAddr) == OFS_PORTB_PD
        |-> pinPullDown == 8'($past(regWdata))) else $error("pull-down not written");
    pullup_read_a: assert property ($past(regRead) && $past(regAddr) == OFS_PORTB_PU
        |-> regRdata == {24'h0, $past(pinPullUp)}) else $error("pull-up read wrong");
    porta_read_a: assert property ($past(regRead) && $past(regAddr) == OFS_PORTA_OD
        |-> regRdata == {24'h0, $past(portaOpenDrain)}) else $error("first port read wrong");
    irq_gate_a: assert property ((extIrq & ~pinIn[2:0]) == 3'h0)
        else $error("interrupt without pin level");
endmodule : gpp_port_checker

bind gpp_port gpp_port_checker u_chk (.core_clk(core_clk), .rst(rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .pinIn(pinIn), .pinOe(pinOe), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown),
    .extIrq(extIrq), .portaOpenDrain(portaOpenDrain));

// *** gpp_board.sv ***
// board model: resolves each pad from port drive, board drive and pulls
// assumes levels settle within a core_clk cycle; floating pins toggle
`timescale 1ns/100ps
module gpp_board
(
    // port side
    input  wire logic       core_clk,
    input  wire logic [7:0] pinOut,
    input  wire logic [7:0] pinOe,
    input  wire logic [7:0] pinPullUp,
    input  wire logic [7:0] pinPullDown,
    // board side
    input  wire logic [7:0] extVal,
    input  wire logic [7:0] extEn,
    output logic      [7:0] pinIn
);
    logic floatLvl = 1'b0;
    // a floating pin shows a level that changes every cycle
    always @(posedge core_clk)
        floatLvl <= ~floatLvl;
    // wired-and of both drivers, then resistors, else floating
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            if (pinOe[i] || extEn[i])
                pinIn[i] = (pinOut[i] | ~pinOe[i]) & (extVal[i] | ~extEn[i]);
            else if (pinPullUp[i] || pinPullDown[i])
                pinIn[i] = pinPullUp[i];
            else
                pinIn[i] = floatLvl;
        end
    end
endmodule : gpp_board

// *** gpp_port_tb_top.sv ***
// testbench for the eight-bit port: register table, pads, reset
// assumes the board model feeds the pad inputs and the checker is bound
`timescale 1ns/100ps
module gpp_port_tb_top
    import gpp_pkg::*;
;
    typedef struct packed { logic [11:0] a; logic [7:0] w; logic [31:0] e; } gpp_row_s;
    logic        core_clk = 1'b0, rst = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [11:0] regAddr = 12'h0;
    logic [31:0] regWdata = 32'h0, regRdata;
    logic [7:0]  pinIn, pinOut, pinOe, pinPullUp, pinPullDown, adcIn, extVal = 8'h0, extEn = 8'h0;
    logic [7:0]  portaOpenDrain, portaPullUp, portaPullDown, portaInputEn;
    logic [2:0]  extIrq;
    int          num_errors = 0, compares = 0;
    // offset, low byte written under ones, word read back
    gpp_row_s    rows [10] = '{'{OFS_PORTB_OE, 8'h81, 32'h81}, '{OFS_PORTB_OD, 8'h42, 32'h42},
        '{OFS_PORTB_PU, 8'h24, 32'h24}, '{OFS_PORTB_PD, 8'h18, 32'h18},
        '{OFS_PORTB_IE, 8'h3C, 32'h3C}, '{OFS_PORTB_FSEL1, 8'hFF, 32'h07},
        '{OFS_PORTA_OD, 8'h11, 32'h11}, '{OFS_PORTA_PU, 8'h22, 32'h22},
        '{OFS_PORTA_PD, 8'h44, 32'h44}, '{OFS_PORTA_IE, 8'h88, 32'h88}};
    gpp_port DUT (.core_clk(core_clk), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .pinIn(pinIn),
        .pinOut(pinOut), .pinOe(pinOe), .pinPullUp(pinPullUp), .pinPullDown(pinPullDown),
        .adcIn(adcIn), .extIrq(extIrq), .portaOpenDrain(portaOpenDrain),
        .portaPullUp(portaPullUp), .portaPullDown(portaPullDown), .portaInputEn(portaInputEn));
    gpp_board u_board (.core_clk(core_clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullUp(pinPullUp), .pinPullDown(pinPullDown), .extVal(extVal), .extEn(extEn),
        .pinIn(pinIn));
    // compare and count
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one-cycle write strobe
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr  <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge core_clk);
        regWrite <= 1'b0;
        #1;
    endtask : wr
    // one-cycle read strobe; data looked at in the next cycle only
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge core_clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge core_clk);
        regRead <= 1'b0;
        #1;
        chk("read data", e, regRdata);
    endtask : rd
    // counts, verdict, end of run
    task automatic print_verdict;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : print_verdict
    // 8 ns core clock
    initial
        forever #4 core_clk = ~core_clk;
    // hang guard, far beyond the run length
    initial
    begin
        #40000;
        num_errors++;
        print_verdict();
    end
    // main sequence
    initial
    begin
        repeat (10) @(posedge core_clk);
        rst <= 1'b0;
        foreach (rows[i]) rd(rows[i].a, 32'h0);
        foreach (rows[i]) wr(rows[i].a, {24'hFF_FFFF, rows[i].w});
        foreach (rows[i]) rd(rows[i].a, rows[i].e);
        chk("pull-up", 8'h24, pinPullUp);
        chk("pull-down", 8'h18, pinPullDown);
        chk("first port", 8'h11, portaOpenDrain);
        chk("first port pull-up", 8'h22, portaPullUp);
        chk("first port pull-down", 8'h44, portaPullDown);
        chk("first port input", 8'h88, portaInputEn);
        $display("test rows done");
        // reset in mid-run clears every control
        @(posedge core_clk);
        rst <= 1'b1;
        @(posedge core_clk);
        rst <= 1'b0;
        #1;
        chk("after reset", 8'h0, pinOe | pinPullUp | portaInputEn);
        $display("test reset done");
        // per-pin drive, then open drain on pins 0 and 1
        wr(OFS_PORTB_OE, 32'h0F);
        wr(OFS_PORTB_DATA, 32'h05);
        chk("drive", 8'h0F, pinOe);
        chk("out", 4'h5, pinOut[3:0]);
        wr(OFS_PORTB_OD, 32'h03);
        chk("open drain", 8'h0E, pinOe);
        chk("open drain out", 2'h0, pinOut[1:0]);
        // input path gated by the input enable
        @(posedge core_clk);
        extEn  <= 8'hF0;
        extVal <= 8'hA0;
        wr(OFS_PORTB_IE, 32'h30);
        rd(OFS_PORTB_DATA, 32'h20);
        wr(OFS_PORTB_IE, 32'h0);
        rd(OFS_PORTB_DATA, 32'h0);
        // interrupt inputs on pins 2..0 and raw converter feed
        wr(OFS_PORTB_OE, 32'h0);
        @(posedge core_clk);
        extEn  <= 8'hFF;
        extVal <= 8'hA5;
        wr(OFS_PORTB_FSEL1, 32'h07);
        wr(OFS_PORTB_IE, 32'h07);
        chk("interrupt", 3'h5, extIrq);
        chk("converter", 8'hA5, adcIn);
        // alternate-function pins never drive, port pins do
        wr(OFS_PORTB_OE, 32'hFF);
        chk("alt no drive", 8'hF8, pinOe);
        $display("test pads done");
        // unmapped offset: write dropped, read zero
        wr(12'h00C, 32'hFF);
        rd(12'h00C, 32'h0);
        rd(OFS_PORTB_IE, 32'h07);
        $display("test bus done");
        print_verdict();
    end
endmodule : gpp_port_tb_top
